/* File: hdl/net_config_register_bank.sv */
`timescale 1ns/1ps
module net_config_register_bank (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic [2:0]  irq_event_set,
    input  wire logic [3:0]  socket_irq,
    output logic      [7:0]  reg_rdata,
    output logic             irq_out_n,
    output logic             ping_reply_block,
    output logic             pppoe_enable,
    output logic             soft_reset_active,
    output logic      [31:0] gateway_ip_address,
    output logic      [31:0] subnet_mask,
    output logic      [47:0] source_mac_address,
    output logic      [31:0] source_ip_address
);
    typedef struct packed {
        logic                                ping_block;
        logic                                pppoe;
        logic [net_cfg_pkg::NET_BYTES-1:0][7:0] net_bytes;
        logic [2:0]                          irq_wc;
        logic [7:0]                          irq_mask;
        logic                                locked;
        logic [7:0]                          rdata;
    } bank_state_t;

    bank_state_t state;
    bank_state_t next_state;
    logic        soft_start;
    logic        init;
    logic        net_hit;
    logic [4:0]  net_index;
    logic [7:0]  status_value;
    logic [7:0]  mode_value;
    logic [7:0]  read_value;
    logic        pending;
    logic [15:0] holdoff_value;

    // Soft reset is requested on a one in the top mode bit
    assign soft_start = reg_wr && (reg_addr == net_cfg_pkg::MODE_OFFSET)
                        && reg_wdata[net_cfg_pkg::SOFT_RESET_BIT];
    assign init       = !rst_n || soft_reset_active;

    soft_reset_stretcher u_soft_reset (
        .clock  (clock),
        .rst_n  (rst_n),
        .start  (soft_start),
        .active (soft_reset_active)
    );

    // Address decode of the byte array covering offsets 0x01 to 0x14
    assign net_hit   = (reg_addr >= net_cfg_pkg::GATEWAY_OFFSET) && (reg_addr < net_cfg_pkg::IRQ_STATUS_OFFSET);
    assign net_index = 5'(reg_addr - net_cfg_pkg::GATEWAY_OFFSET);

    // Composite read values; reserved and zero-only bits read zero, one-only bits read one
    assign mode_value   = {soft_reset_active, 2'b00, state.ping_block, state.pppoe, 3'b000}
                          | net_cfg_pkg::MODE_ONE_BITS;
    assign status_value = {state.irq_wc, 1'b0, socket_irq};
    assign pending      = |(status_value & state.irq_mask);

    // Most significant byte sits at the lowest offset
    assign holdoff_value = {state.net_bytes[net_cfg_pkg::HOLDOFF_HI_INDEX],
                            state.net_bytes[net_cfg_pkg::HOLDOFF_LO_INDEX]};
    assign gateway_ip_address = {state.net_bytes[0], state.net_bytes[1], state.net_bytes[2],
                                 state.net_bytes[3]};
    assign subnet_mask        = {state.net_bytes[4], state.net_bytes[5], state.net_bytes[6],
                                 state.net_bytes[7]};
    assign source_mac_address = {state.net_bytes[8], state.net_bytes[9], state.net_bytes[10],
                                 state.net_bytes[11], state.net_bytes[12], state.net_bytes[13]};
    assign source_ip_address  = {state.net_bytes[14], state.net_bytes[15], state.net_bytes[16],
                                 state.net_bytes[17]};

    assign ping_reply_block = state.ping_block;
    assign pppoe_enable     = state.pppoe;
    assign reg_rdata        = state.rdata;

    // Read multiplexer
    always_comb begin
        read_value = net_cfg_pkg::UNMAPPED_READ;
        if (reg_addr == net_cfg_pkg::MODE_OFFSET) begin
            read_value = mode_value;
        end else if (net_hit) begin
            read_value = state.net_bytes[net_index];
        end else if (reg_addr == net_cfg_pkg::IRQ_STATUS_OFFSET) begin
            read_value = status_value;
        end else if (reg_addr == net_cfg_pkg::IRQ_MASK_OFFSET) begin
            read_value = state.irq_mask;
        end else if (reg_addr == net_cfg_pkg::NET_LOCK_OFFSET) begin
            read_value = {7'h00, state.locked};
        end
    end

    // Register updates; event set beats a same-cycle host clear
    always_comb begin
        next_state = state;
        if (reg_rd) begin
            next_state.rdata = read_value;
        end
        if (reg_wr) begin
            if (reg_addr == net_cfg_pkg::MODE_OFFSET) begin
                // Zero-only bits are ignored on write, relying on the host to keep them zero
                next_state.ping_block = reg_wdata[net_cfg_pkg::PING_BLOCK_BIT];
                next_state.pppoe      = reg_wdata[net_cfg_pkg::PPPOE_BIT];
            end else if (net_hit) begin
                if (net_index >= net_cfg_pkg::NET_LOCKED_BYTES || !state.locked) begin
                    next_state.net_bytes[net_index] = reg_wdata;
                end
            end else if (reg_addr == net_cfg_pkg::IRQ_STATUS_OFFSET) begin
                next_state.irq_wc = state.irq_wc & ~reg_wdata[7:5];
            end else if (reg_addr == net_cfg_pkg::IRQ_MASK_OFFSET) begin
                next_state.irq_mask = reg_wdata & net_cfg_pkg::IRQ_MASK_USED;
            end else if (reg_addr == net_cfg_pkg::NET_LOCK_OFFSET) begin
                if (reg_wdata == net_cfg_pkg::NET_LOCK_KEY) begin
                    next_state.locked = 1'b1;
                end else if (reg_wdata == net_cfg_pkg::NET_UNLOCK_KEY) begin
                    next_state.locked = 1'b0;
                end
            end
        end
        for (int i = 0; i < 3; i++) begin
            if (irq_event_set[i]) begin
                next_state.irq_wc[i] = 1'b1;
            end
        end
    end

    // Whole bank returns to reset values on either reset
    always_ff @(posedge clock) begin
        if (init) begin
            state          <= '0;
            state.irq_mask <= net_cfg_pkg::IRQ_MASK_RESET;
            state.locked   <= net_cfg_pkg::NET_LOCK_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Holdoff timer gates the enabled events onto the interrupt pin
    irq_holdoff_timer u_holdoff (
        .clock     (clock),
        .init      (init),
        .pending   (pending),
        .reload    (holdoff_value),
        .irq_out_n (irq_out_n)
    );

    sequence s_mode_read;
        reg_rd && reg_addr == net_cfg_pkg::MODE_OFFSET;
    endsequence
    property p_mode_reset;
        @(posedge clock) disable iff (!rst_n)
            $fell(soft_reset_active) ##0 s_mode_read |=> reg_rdata == net_cfg_pkg::MODE_RESET;
    endproperty
    a_mode_reset: assert property (p_mode_reset) else $error("mode not 0x03 after reset");

    sequence s_locked_write;
        reg_wr && state.locked && !init && reg_addr >= net_cfg_pkg::GATEWAY_OFFSET
        && reg_addr < net_cfg_pkg::HOLDOFF_OFFSET;
    endsequence
    property p_lock_blocks;
        @(posedge clock) disable iff (init) s_locked_write |=>
            $stable(gateway_ip_address) && $stable(subnet_mask) && $stable(source_mac_address)
            && $stable(source_ip_address);
    endproperty
    a_lock_blocks: assert property (p_lock_blocks) else $error("locked network register changed");

    property p_unlocked_write;
        @(posedge clock) disable iff (init)
            (reg_wr && !state.locked && reg_addr == net_cfg_pkg::GATEWAY_OFFSET) |=>
            gateway_ip_address[31:24] == $past(reg_wdata);
    endproperty
    a_unlocked_write: assert property (p_unlocked_write) else $error("unlocked gateway write lost");

    property p_wc_clear;
        @(posedge clock) disable iff (init)
            (reg_wr && reg_addr == net_cfg_pkg::IRQ_STATUS_OFFSET && reg_wdata[7] && !irq_event_set[2])
            |=> !state.irq_wc[2];
    endproperty
    a_wc_clear: assert property (p_wc_clear) else $error("write one did not clear");

    property p_set_wins;
        @(posedge clock) disable iff (init) irq_event_set[0] |=> state.irq_wc[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost against clear");

    property p_mask_readback;
        @(posedge clock) disable iff (init)
            (reg_wr && reg_addr == net_cfg_pkg::IRQ_MASK_OFFSET) ##1
            (reg_rd && reg_addr == net_cfg_pkg::IRQ_MASK_OFFSET && !reg_wr) |=>
            reg_rdata == ($past(reg_wdata, 2) & net_cfg_pkg::IRQ_MASK_USED);
    endproperty
    a_mask_readback: assert property (p_mask_readback) else $error("mask readback mismatch");

    property p_ping_block;
        @(posedge clock) disable iff (init)
            (reg_wr && reg_addr == net_cfg_pkg::MODE_OFFSET && !reg_wdata[7]) |=>
            ping_reply_block == $past(reg_wdata[4]) && pppoe_enable == $past(reg_wdata[3]);
    endproperty
    a_ping_block: assert property (p_ping_block) else $error("mode control bits wrong");

    property p_irq_release;
        @(posedge clock) disable iff (init) !pending |=> irq_out_n;
    endproperty
    a_irq_release: assert property (p_irq_release) else $error("interrupt held without event");

    // Lock key closes the address registers, unlock key opens them
    property p_lock_key;
        @(posedge clock) disable iff (init)
            (reg_wr && reg_addr == net_cfg_pkg::NET_LOCK_OFFSET && reg_wdata == net_cfg_pkg::NET_LOCK_KEY) |=> state.locked;
    endproperty
    a_lock_key: assert property (p_lock_key) else $error("lock key not taken");

    property p_unlock_key;
        @(posedge clock) disable iff (init)
            (reg_wr && reg_addr == net_cfg_pkg::NET_LOCK_OFFSET && reg_wdata == net_cfg_pkg::NET_UNLOCK_KEY) |=> !state.locked;
    endproperty
    a_unlock_key: assert property (p_unlock_key) else $error("unlock key not taken");

    // Each address register takes its top byte while unlocked
    property p_subnet_write;
        @(posedge clock) disable iff (init)
            (reg_wr && !state.locked && reg_addr == net_cfg_pkg::SUBNET_OFFSET) |=> subnet_mask[31:24] == $past(reg_wdata);
    endproperty
    a_subnet_write: assert property (p_subnet_write) else $error("unlocked subnet write lost");

    property p_mac_write;
        @(posedge clock) disable iff (init)
            (reg_wr && !state.locked && reg_addr == net_cfg_pkg::MAC_OFFSET) |=> source_mac_address[47:40] == $past(reg_wdata);
    endproperty
    a_mac_write: assert property (p_mac_write) else $error("unlocked mac write lost");

    property p_source_ip_write;
        @(posedge clock) disable iff (init)
            (reg_wr && !state.locked && reg_addr == net_cfg_pkg::SOURCE_IP_OFFSET) |=> source_ip_address[31:24] == $past(reg_wdata);
    endproperty
    a_source_ip_write: assert property (p_source_ip_write) else $error("unlocked source ip write lost");

    // Holdoff bytes stay writable under the lock; high byte first
    property p_holdoff_hi;
        @(posedge clock) disable iff (init)
            (reg_wr && reg_addr == net_cfg_pkg::HOLDOFF_OFFSET) |=> holdoff_value[15:8] == $past(reg_wdata);
    endproperty
    a_holdoff_hi: assert property (p_holdoff_hi) else $error("holdoff high byte lost");

    property p_holdoff_lo;
        @(posedge clock) disable iff (init)
            (reg_wr && reg_addr == (net_cfg_pkg::HOLDOFF_OFFSET + 8'h01)) |=> holdoff_value[7:0] == $past(reg_wdata);
    endproperty
    a_holdoff_lo: assert property (p_holdoff_lo) else $error("holdoff low byte lost");

    // Read data is the selected value, and holds between reads
    property p_read_data;
        @(posedge clock) disable iff (init)
            reg_rd |=> reg_rdata == $past(read_value);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data not the addressed value");

    property p_rdata_hold;
        @(posedge clock) disable iff (init)
            !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

    property p_mode_fixed_bits;
        @(posedge clock) disable iff (init)
            s_mode_read |=> reg_rdata[2:0] == 3'h3 && reg_rdata[6:5] == 2'h0;
    endproperty
    a_mode_fixed_bits: assert property (p_mode_fixed_bits) else $error("mode fixed bits wrong");

    // A written zero leaves a pending event alone
    property p_wc_zero_keeps;
        @(posedge clock) disable iff (init)
            (reg_wr && reg_addr == net_cfg_pkg::IRQ_STATUS_OFFSET && !reg_wdata[5] && state.irq_wc[0]) |=> state.irq_wc[0];
    endproperty
    a_wc_zero_keeps: assert property (p_wc_zero_keeps) else $error("write zero cleared an event");

    property p_status_read;
        @(posedge clock) disable iff (init)
            (reg_rd && reg_addr == net_cfg_pkg::IRQ_STATUS_OFFSET) |=> reg_rdata[4:0] == {1'b0, $past(socket_irq)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status socket bits wrong");

    // Soft reset wipes the bank while it stands
    property p_soft_clears;
        @(posedge clock) disable iff (!rst_n)
            soft_reset_active |=> gateway_ip_address == 32'h00000000 && !ping_reply_block && !pppoe_enable;
    endproperty
    a_soft_clears: assert property (p_soft_clears) else $error("soft reset left state behind");
endmodule : net_config_register_bank

/* File: hdl/net_cfg_pkg.sv */
package net_cfg_pkg;
    // Register offsets on the host byte bus
    localparam logic [7:0] MODE_OFFSET         = 8'h00;
    localparam logic [7:0] GATEWAY_OFFSET      = 8'h01;
    localparam logic [7:0] SUBNET_OFFSET       = 8'h05;
    localparam logic [7:0] MAC_OFFSET          = 8'h09;
    localparam logic [7:0] SOURCE_IP_OFFSET    = 8'h0F;
    localparam logic [7:0] HOLDOFF_OFFSET      = 8'h13;
    localparam logic [7:0] IRQ_STATUS_OFFSET   = 8'h15;
    localparam logic [7:0] IRQ_MASK_OFFSET     = 8'h16;
    localparam logic [7:0] NET_LOCK_OFFSET     = 8'h71;

    // Byte array holding offsets 0x01 to 0x14
    localparam int         NET_BYTES           = 20;
    localparam logic [4:0] NET_LOCKED_BYTES    = 5'h12;
    localparam logic [4:0] HOLDOFF_HI_INDEX    = 5'h12;
    localparam logic [4:0] HOLDOFF_LO_INDEX    = 5'h13;

    // Mode register layout and reset value
    localparam int         SOFT_RESET_BIT      = 7;
    localparam int         PING_BLOCK_BIT      = 4;
    localparam int         PPPOE_BIT           = 3;
    localparam logic [7:0] MODE_RESET          = 8'h03;
    localparam logic [7:0] MODE_ONE_BITS       = 8'h03;

    // Interrupt status layout
    localparam logic [7:0] IRQ_WC_BITS         = 8'hE0;
    localparam logic [7:0] IRQ_MASK_USED       = 8'hEF;
    localparam logic [7:0] IRQ_MASK_RESET      = 8'h00;

    // Lock keys written to the lock register
    localparam logic [7:0] NET_LOCK_KEY        = 8'hC5;
    localparam logic [7:0] NET_UNLOCK_KEY      = 8'h3A;
    localparam logic       NET_LOCK_RESET      = 1'b0;

    // Cycle counts at the system clock, and the value read at unmapped offsets
    localparam logic [1:0] SOFT_RESET_CYCLES   = 2'h3;
    localparam logic [1:0] HOLDOFF_TICK_LAST   = 2'h3;
    localparam logic [7:0] UNMAPPED_READ       = 8'h00;
endpackage : net_cfg_pkg

/* File: hdl/soft_reset_stretcher.sv */
`timescale 1ns/1ps
module soft_reset_stretcher (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      active
);
    typedef struct packed {
        logic [1:0] count;
    } stretch_state_t;

    stretch_state_t state;
    stretch_state_t next_state;

    assign active = (state.count != 2'h0);

    // Hold the reset pulse for a fixed count, then clear by itself
    always_comb begin
        next_state = state;
        if (start && !active) begin
            next_state.count = net_cfg_pkg::SOFT_RESET_CYCLES;
        end else if (active) begin
            next_state.count = state.count - 2'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    sequence s_three_active;
        active [*3] ##1 !active;
    endsequence
    property p_soft_reset_len;
        @(posedge clock) disable iff (!rst_n) (start && !active) |=> s_three_active;
    endproperty
    a_soft_reset_len: assert property (p_soft_reset_len) else $error("soft reset not three cycles");
endmodule : soft_reset_stretcher

/* File: hdl/irq_holdoff_timer.sv */
`timescale 1ns/1ps
module irq_holdoff_timer (
    input  wire logic        clock,
    input  wire logic        init,
    input  wire logic        pending,
    input  wire logic [15:0] reload,
    output logic             irq_out_n
);
    typedef struct packed {
        logic        irq_n;
        logic [15:0] count;
        logic [1:0]  prescale;
    } holdoff_state_t;

    holdoff_state_t state;
    holdoff_state_t next_state;

    assign irq_out_n = state.irq_n;

    // Low only with an enabled event and an expired counter; rises as soon as the event goes
    always_comb begin
        next_state       = state;
        next_state.irq_n = !(pending && (state.count == 16'h0000));
        if (!state.irq_n && next_state.irq_n) begin
            next_state.count    = reload;
            next_state.prescale = 2'h0;
        end else if (state.count != 16'h0000) begin
            next_state.prescale = state.prescale + 2'h1;
            if (state.prescale == net_cfg_pkg::HOLDOFF_TICK_LAST) begin
                next_state.count = state.count - 16'h0001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (init) begin
            state <= '{irq_n: 1'b1, count: 16'h0000, prescale: 2'h0};
        end else begin
            state <= next_state;
        end
    end

    property p_reload;
        @(posedge clock) disable iff (init) $rose(state.irq_n) |-> state.count == $past(reload);
    endproperty
    a_reload: assert property (p_reload) else $error("holdoff counter not reloaded");

    property p_tick;
        @(posedge clock) disable iff (init)
            (state.count != 16'h0000 && state.prescale == 2'h0 && !$rose(state.irq_n)) |->
            ##3 (state.count == $past(state.count, 3)) ##1 (state.count == $past(state.count, 4) - 16'h0001);
    endproperty
    a_tick: assert property (p_tick) else $error("holdoff tick not every four cycles");

    property p_low_needs_zero;
        @(posedge clock) disable iff (init) $fell(state.irq_n) |-> $past(state.count) == 16'h0000;
    endproperty
    a_low_needs_zero: assert property (p_low_needs_zero) else $error("interrupt asserted during holdoff");
endmodule : irq_holdoff_timer

/* File: verification/host_model.sv */
`timescale 1ns/1ps
module host_model (
    input  wire logic       clock,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    output logic      [2:0] irq_event_set,
    output logic      [3:0] socket_irq
);
    // Quiet bus at time zero
    initial begin
        reg_addr      = 8'hFF;
        reg_wr        = 1'b0;
        reg_rd        = 1'b0;
        reg_wdata     = 8'h00;
        irq_event_set = 3'h0;
        socket_irq    = 4'h0;
    end

    // One byte write; mode writes force bits 6:5 to zero and bits 1:0 to one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr  = a;
        reg_wdata = (a == net_cfg_pkg::MODE_OFFSET) ? ((d & 8'h9F) | net_cfg_pkg::MODE_ONE_BITS) : d;
        reg_wr    = 1'b1;
        @(negedge clock);
        reg_wr    = 1'b0;
        reg_wdata = ~reg_wdata; // Stale data is not left on the lines
        reg_addr  = ~reg_addr;
    endtask : wr

    // One byte read; data is settled one edge after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clock);
        d        = reg_rdata;
        reg_rd   = 1'b0;
        reg_addr = ~reg_addr;
    endtask : rd

    // Single-cycle event pulse
    task automatic pulse(input logic [2:0] e);
        @(negedge clock);
        irq_event_set = e;
        @(negedge clock);
        irq_event_set = 3'h0;
    endtask : pulse
endmodule : host_model

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic        clock;
    logic        rst_n;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_wdata;
    logic [2:0]  irq_event_set;
    logic [3:0]  socket_irq;
    logic [7:0]  reg_rdata;
    logic        irq_out_n;
    logic        ping_reply_block;
    logic        pppoe_enable;
    logic        soft_reset_active;
    logic [31:0] gateway_ip_address;
    logic [31:0] subnet_mask;
    logic [47:0] source_mac_address;
    logic [31:0] source_ip_address;
    int          num_errors;
    int          checks;
    int          seed;
    int          i;
    int          n;
    logic [7:0]  m [0:20];
    logic        locked;

    net_config_register_bank u_net_config_register_bank (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .irq_event_set(irq_event_set),
        .socket_irq(socket_irq), .reg_rdata(reg_rdata), .irq_out_n(irq_out_n),
        .ping_reply_block(ping_reply_block), .pppoe_enable(pppoe_enable),
        .soft_reset_active(soft_reset_active), .gateway_ip_address(gateway_ip_address),
        .subnet_mask(subnet_mask), .source_mac_address(source_mac_address),
        .source_ip_address(source_ip_address));

    host_model u_host (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .irq_event_set(irq_event_set), .socket_irq(socket_irq));

    // 20 MHz clock
    initial clock = 1'b0;
    always #25 clock = ~clock;

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.rd(a, d);
        chk({40'h0, d}, {40'h0, exp});
    endtask : rd_chk

    // Write through the host and mirror it in the reference model
    task automatic wr_m(input logic [7:0] a, input logic [7:0] d);
        u_host.wr(a, d);
        if (a == net_cfg_pkg::MODE_OFFSET) m[0] = (d & 8'h18) | 8'h03;
        else if (a >= 8'h01 && a <= 8'h12 && !locked) m[a] = d;
        else if (a == 8'h13 || a == 8'h14) m[a] = d;
        else if (a == net_cfg_pkg::NET_LOCK_OFFSET && d == net_cfg_pkg::NET_LOCK_KEY) locked = 1'b1;
        else if (a == net_cfg_pkg::NET_LOCK_OFFSET && d == net_cfg_pkg::NET_UNLOCK_KEY) locked = 1'b0;
    endtask : wr_m

    // Model back to reset values, then bytes 0x00 to 0x14 and the four address outputs against it
    task automatic model_reset();
        for (int k = 0; k < 21; k++) m[k] = 8'h00;
        m[0]   = 8'h03;
        locked = 1'b0;
    endtask : model_reset

    task automatic all_chk();
        for (int k = 0; k < 21; k++) rd_chk(8'(k), m[k]);
        chk({16'h0, gateway_ip_address}, {16'h0, m[1], m[2], m[3], m[4]});
        chk({16'h0, subnet_mask}, {16'h0, m[5], m[6], m[7], m[8]});
        chk(source_mac_address, {m[9], m[10], m[11], m[12], m[13], m[14]});
        chk({16'h0, source_ip_address}, {16'h0, m[15], m[16], m[17], m[18]});
    endtask : all_chk

    // Bounded wait for a given interrupt level; n is cycles spent
    task automatic wait_irq(input logic lvl, input int lim);
        n = 0;
        while (irq_out_n !== lvl && n < lim) begin
            @(negedge clock);
            n++;
        end
        chk({47'h0, irq_out_n}, {47'h0, lvl});
    endtask : wait_irq

    task automatic rand_writes();
        for (int k = 0; k < 40; k++) wr_m(8'(1 + ($unsigned($random(seed)) % 20)), 8'($random(seed)));
    endtask : rand_writes

    task automatic summarize();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    // Cuts a hang short; the full sequence needs well under 6000 cycles
    initial begin
        #(50 * 20000);
        num_errors++;
        summarize();
    end

    initial begin
        num_errors = 0;
        checks     = 0;
        seed       = 4277;
        rst_n      = 1'b0;
        model_reset();
        repeat (3) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        all_chk();
        // Unlocked random traffic, then locked traffic that bytes 0x01 to 0x12 must refuse
        rand_writes();
        all_chk();
        wr_m(net_cfg_pkg::NET_LOCK_OFFSET, net_cfg_pkg::NET_LOCK_KEY);
        rand_writes();
        all_chk();
        wr_m(net_cfg_pkg::NET_LOCK_OFFSET, net_cfg_pkg::NET_UNLOCK_KEY);
        rd_chk(8'h30, net_cfg_pkg::UNMAPPED_READ);
        // Mode bits drive their outputs
        wr_m(8'h00, 8'h18);
        rd_chk(8'h00, 8'h1B);
        chk({46'h0, ping_reply_block, pppoe_enable}, 48'h3);
        wr_m(8'h00, 8'h08);
        chk({46'h0, ping_reply_block, pppoe_enable}, 48'h1);
        wr_m(8'h00, 8'h10);
        chk({46'h0, ping_reply_block, pppoe_enable}, 48'h2);
        // Interrupt with holdoff of two ticks
        wr_m(8'h13, 8'h00);
        wr_m(8'h14, 8'h02);
        wr_m(net_cfg_pkg::IRQ_MASK_OFFSET, 8'h20);
        u_host.pulse(3'h1);
        wait_irq(1'b0, 20);
        rd_chk(net_cfg_pkg::IRQ_STATUS_OFFSET, 8'h20);
        u_host.wr(net_cfg_pkg::IRQ_STATUS_OFFSET, 8'h00);
        repeat (3) @(negedge clock);
        chk({47'h0, irq_out_n}, 48'h0);
        u_host.wr(net_cfg_pkg::IRQ_STATUS_OFFSET, 8'h20);
        wait_irq(1'b1, 3);
        u_host.pulse(3'h1);
        wait_irq(1'b0, 20);
        chk({47'h0, n >= 5 && n <= 12}, 48'h1);
        wr_m(net_cfg_pkg::IRQ_MASK_OFFSET, 8'h00);
        wait_irq(1'b1, 3);
        // Socket level source
        wr_m(net_cfg_pkg::IRQ_MASK_OFFSET, 8'h01);
        u_host.socket_irq = 4'h1;
        wait_irq(1'b0, 20);
        u_host.socket_irq = 4'h0;
        wait_irq(1'b1, 3);
        // Soft reset stretches three cycles then restores everything
        u_host.wr(8'h00, 8'h80);
        n = 0;
        for (i = 0; i < 6; i++) begin
            if (soft_reset_active === 1'b1) n++;
            @(negedge clock);
        end
        chk(48'(n), 48'h3);
        model_reset();
        all_chk();
        rd_chk(net_cfg_pkg::IRQ_MASK_OFFSET, 8'h00);
        chk({46'h0, ping_reply_block, pppoe_enable}, 48'h0);
        summarize();
    end
endmodule : testbench
